// ---- verif/fps_checker.sv ----
// Checker for the phase sequencer: phase flags, density, gating and request timing.
// Assumes it is bound to fps_sequencer and sees only that module's ports.
`timescale 1ns/1ps

// ==========================================================
// Checker
module fps_checker (
	input wire logic                       clk_i,
	input wire logic                       nrst_i,
	input wire logic [fps_pkg::BYTE_W-1:0] disk_option_config_reg_i,
	input wire logic [fps_pkg::BYTE_W-1:0] digital_output_reg_o,
	input wire logic                       high_density_i,
	input wire logic                       density_select_o,
	input wire logic                       host_wr_i,
	input wire logic                       host_rd_i,
	input wire logic                       host_service_request_flag_o,
	input wire logic                       transfer_direction_flag_o,
	input wire logic                       command_busy_flag_o,
	input wire logic                       irq_o,
	input wire logic                       dma_req_o,
	input wire logic                       terminal_count_input_i,
	input wire logic                       exec_active_o,
	input wire logic                       exec_to_host_o
);
	import fps_pkg::*;
	logic [1:0] up_r;
	// Decoded helpers: out of pin reset and the output-register reset bit, gate open, flag shorthands
	wire rdy = up_r == 2'h3 && !digital_output_reg_o[DOR_RST_BIT];
	wire gate = disk_option_config_reg_i[CFG_MODE_HI:CFG_MODE_LO] == MODE_ALT || digital_output_reg_o[DOR_DMA_BIT];
	wire svc = host_service_request_flag_o;
	wire dir = transfer_direction_flag_o;
	// Cycles since reset release, saturating past the reset synchroniser
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			up_r <= 2'h0;
		else if (up_r != 2'h3)
			up_r <= up_r + 2'h1;
	end
	default clocking ck @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	// ==========================================================
	// Assertions
	a_reset_state: assert property ($rose(nrst_i) |-> digital_output_reg_o == DOR_RESET_VAL && !svc)
		else $error("output register or flags wrong after reset");
	a_density_mode: assert property (rdy && $past(rdy) |-> density_select_o ==
		($past(disk_option_config_reg_i[CFG_MODE_HI]) ? $past(high_density_i) : !$past(high_density_i)))
		else $error("density select polarity wrong for mode");
	a_irq_gated: assert property (irq_o |-> gate || $past(gate))
		else $error("interrupt while gated off");
	a_dma_gated: assert property (dma_req_o |-> gate || $past(gate))
		else $error("dma request while gated off");
	a_req_exec: assert property (dma_req_o |-> exec_active_o || $past(exec_active_o))
		else $error("dma request outside execution");
	a_wr_clear: assert property (rdy && host_wr_i && svc && !dir |=> !svc)
		else $error("service flag kept after host write");
	a_exec_quiet: assert property (exec_active_o |-> !svc && command_busy_flag_o)
		else $error("service flag or busy wrong in execution");
	a_rd_clear: assert property (rdy && host_rd_i && svc && dir |=> !dir && svc != command_busy_flag_o)
		else $error("service flag kept after result read");
	a_result_irq: assert property (rdy && $fell(exec_active_o) && digital_output_reg_o[DOR_DMA_BIT]
		|-> ##2 irq_o && svc && dir) else $error("result phase not entered with interrupt");
	a_busy_done: assert property (rdy && $fell(command_busy_flag_o) |-> svc && !dir)
		else $error("flags wrong when busy clears");
	a_tc_halt: assert property (exec_active_o && terminal_count_input_i |-> ##3 !dma_req_o [*8])
		else $error("dma request after terminal count");
	a_wr_entry: assert property ($rose(exec_active_o) && !exec_to_host_o && gate |-> ##[0:2] dma_req_o)
		else $error("no request on write execution entry");
	c_rd_exec: cover property ($rose(exec_active_o) && exec_to_host_o);
	c_wr_exec: cover property ($rose(exec_active_o) && !exec_to_host_o);
	c_result: cover property ($rose(svc && dir));
endmodule : fps_checker

bind fps_sequencer fps_checker u_chk (.*);

// ---- verif/fps_dma_model.sv ----
// System DMA controller model: one byte per ack while the request stands.
// Assumes one clock; the bench enables it and may slow it down.
`timescale 1ns/1ps

// ==========================================================
// DMA responder
module fps_dma_model (
	input  wire logic        clk_i,
	input  wire logic        en_i,
	input  wire logic        slow_i,
	input  wire logic        dma_req_i,
	output logic             dma_ack_o,
	output logic [7:0]       dma_wdata_o
);
	logic [7:0] seq_r;
	logic [2:0] gap_r;
	initial begin
		dma_ack_o = 1'b0;
		dma_wdata_o = 8'hFF;
		seq_r = 8'h00;
		gap_r = 3'h0;
	end
	// Ack, then pause so the lagging request can settle before the next look
	always @(posedge clk_i) begin
		if (dma_ack_o) begin
			dma_ack_o <= 1'b0;
			dma_wdata_o <= ~dma_wdata_o; // Released lines do not keep the byte
			seq_r <= seq_r + 8'h01;
			gap_r <= slow_i ? 3'h5 : 3'h2;
		end else if (gap_r != 3'h0) begin
			gap_r <= gap_r - 3'h1;
		end else if (en_i && dma_req_i) begin
			dma_ack_o <= 1'b1;
			dma_wdata_o <= seq_r;
		end
	end
endmodule : fps_dma_model

// ---- verif/fps_sequencer_tb_top.sv ----
// Bench for the phase sequencer: modes, commands, results, DMA read and write.
// Assumes fps_dma_model as the DMA side and the bound fps_checker.
`timescale 1ns/1ps

// ==========================================================
// Bench top
module fps_sequencer_tb_top;
	import fps_pkg::*;
	logic clk_i, nrst_i, oreg_we, hd, wr, rd, term, rxv, txr, se, en, slow, ack_d, mon;
	logic [7:0] cfg, oreg_wd, wd, rxd, lf, cyl, oreg_q, rdata, dwd, drd, txd;
	logic dens, svc, dir, busy, irq, req, ack, exe, e2h;
	logic [7:0] got[$];
	logic [7:0] fed[$];
	int err_total = 0, check_count = 0, i;
	fps_sequencer uut (.clk_i(clk_i), .nrst_i(nrst_i), .disk_option_config_reg_i(cfg), .dor_we_i(oreg_we),
		.dor_wdata_i(oreg_wd), .digital_output_reg_o(oreg_q), .dsr_reset_i(1'b0), .high_density_i(hd),
		.density_select_o(dens), .host_wr_i(wr), .host_wdata_i(wd), .host_rd_i(rd), .host_rdata_o(rdata),
		.host_service_request_flag_o(svc), .transfer_direction_flag_o(dir), .command_busy_flag_o(busy),
		.irq_o(irq), .dma_req_o(req), .dma_ack_i(ack), .dma_wdata_i(dwd), .dma_rdata_o(drd),
		.terminal_count_input_i(term), .exec_active_o(exe), .exec_to_host_o(e2h), .disk_rx_valid_i(rxv),
		.disk_rx_data_i(rxd), .disk_tx_req_i(txr), .disk_tx_data_o(txd), .disk_sector_end_i(se));
	fps_dma_model u_dma (.clk_i(clk_i), .en_i(en), .slow_i(slow), .dma_req_i(req), .dma_ack_o(ack),
		.dma_wdata_o(dwd));
	// Clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// Bytes read by the DMA side, captured a cycle after each ack
	always @(posedge clk_i) begin
		if (ack_d && mon)
			got.push_back(drd);
		ack_d <= ack;
	end
	function automatic logic [7:0] nx(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : nx
	function automatic logic dexp(input logic [1:0] m, input logic h);
		return m[1] ? h : !h;
	endfunction : dexp
	function automatic logic sel(input int c, input logic v);
		case (c)
			0: return svc === 1'b1 && dir === v;
			1: return exe === v;
			default: return req === v;
		endcase
	endfunction : sel
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wc(input int c, input logic v);
		i = 0;
		do begin
			@(negedge clk_i);
			i++;
		end while (!sel(c, v) && i < 3000);
		chk(sel(c, v), 1'b1);
	endtask : wc
	task automatic put(input logic [7:0] b);
		wc(0, 1'b0);
		@(posedge clk_i) begin wr <= 1'b1; wd <= b; end
		@(posedge clk_i) wr <= 1'b0;
	endtask : put
	task automatic get(input logic [7:0] e, input logic [7:0] m);
		wc(0, 1'b1);
		chk(rdata & m, e);
		@(posedge clk_i) rd <= 1'b1;
		@(posedge clk_i) rd <= 1'b0;
	endtask : get
	task automatic cmd(input logic [7:0] b[$]);
		foreach (b[k]) put(b[k]);
	endtask : cmd
	task automatic xf(input logic [7:0] op);
		cmd('{op, 8'h00, cyl, 8'h00, 8'h01, 8'h02, 8'h01, 8'h1B, 8'hFF});
	endtask : xf
	task automatic res(input logic [7:0] s0, input logic [7:0] s1);
		logic [7:0] e[7];
		logic [7:0] m[7];
		e = '{s0, s1, 8'h00, cyl, 8'h00, 8'h00, 8'h02};
		m = '{8'hC0, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF};
		for (int k = 0; k < 7; k++) get(e[k], m[k]);
	endtask : res
	task automatic rx(input logic s);
		lf = nx(lf);
		fed.push_back(lf);
		@(posedge clk_i) begin rxv <= 1'b1; rxd <= lf; se <= s; end
		@(posedge clk_i) begin rxv <= 1'b0; se <= 1'b0; end
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
	endtask : rx
	task automatic tx(input logic s, input logic [7:0] e, input logic [7:0] m);
		@(posedge clk_i) begin txr <= 1'b1; se <= s; end
		@(posedge clk_i) begin txr <= 1'b0; se <= 1'b0; end
		@(negedge clk_i) chk(txd & m, e);
	endtask : tx
	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict
	// Watchdog, well beyond the few hundred cycles the sequence needs
	initial begin
		#2000000;
		err_total++;
		give_verdict();
	end
	// Main sequence
	initial begin
		{nrst_i, oreg_we, hd, wr, rd, term, rxv, txr, se, en, slow, ack_d, mon} = '0;
		{cfg, oreg_wd, wd, rxd} = '0;
		lf = 8'h40;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(negedge clk_i);
		chk(oreg_q, DOR_RESET_VAL);
		chk(svc, 1'b0);
		@(posedge clk_i) begin oreg_we <= 1'b1; oreg_wd <= 8'h08; end
		@(posedge clk_i) oreg_we <= 1'b0;
		repeat (2) @(negedge clk_i);
		chk({svc, dir, busy}, 8'h04);
		for (int m = 0; m < 4; m++) begin
			lf = nx(lf);
			@(posedge clk_i) begin cfg <= {4'h0, m[1:0], 2'h2}; hd <= lf[0]; end
			repeat (2) @(negedge clk_i);
			chk(dens, dexp(m[1:0], lf[0]));
		end
		put(8'h1F);
		repeat (3) @(negedge clk_i);
		chk(irq, 1'b1);
		put({3'h0, OP_SENSE});
		get(ST0_INVALID, 8'hFF);
		get(SENSE_PCN, 8'hFF);
		wc(0, 1'b0);
		chk(busy, 1'b0);
		cmd('{8'h03, 8'hAF, 8'h00});
		cmd('{8'h13, 8'h00, 8'h0B, 8'h00});
		lf = nx(lf);
		cyl = lf;
		slow = lf[1];
		mon = 1'b1;
		xf(8'h06);
		wc(1, 1'b1);
		chk(e2h, 1'b1);
		repeat (3) rx(1'b0);
		chk(req, 1'b0);
		rx(1'b0);
		chk(req, 1'b1);
		@(posedge clk_i) en <= 1'b1;
		repeat (11) rx(1'b0);
		rx(1'b1);
		wc(1, 1'b0);
		res(ST0_ABNORMAL, ST1_EN);
		foreach (fed[k]) chk(got[k], fed[k]);
		mon = 1'b0;
		@(posedge clk_i) en <= 1'b0;
		xf(8'h05);
		wc(1, 1'b1);
		chk(e2h, 1'b0);
		repeat (3) @(negedge clk_i);
		chk(req, 1'b1);
		@(posedge clk_i) en <= 1'b1;
		wc(2, 1'b0);
		@(posedge clk_i) en <= 1'b0;
		// The DMA model's byte sequence carries on from the read, one value per ack
		for (int k = 0; k < 3; k++) tx(1'b0, 8'(fed.size() + k), 8'hFF);
		repeat (2) @(negedge clk_i);
		chk(req, 1'b0);
		tx(1'b0, 8'(fed.size() + 3), 8'hFF);
		repeat (2) @(negedge clk_i);
		chk(req, 1'b1);
		@(posedge clk_i) begin term <= 1'b1; en <= 1'b1; end
		@(posedge clk_i) term <= 1'b0;
		repeat (4) @(negedge clk_i);
		chk(req, 1'b0);
		// Disk drains the twelve bytes still queued, then takes fill up to the sector end
		for (int k = 4; k < 16; k++) tx(1'b0, 8'(fed.size() + k), 8'hFF);
		tx(1'b0, TX_FILL, 8'hFF);
		tx(1'b1, TX_FILL, 8'hFF);
		wc(1, 1'b0);
		res(ST_CLEAR, ST_CLEAR);
		give_verdict();
	end
endmodule : fps_sequencer_tb_top

// ---- verilog/fps_pkg.sv ----
// Constants, field positions and phase codes for the floppy phase/DMA sequencer.
// Assumes a single system clock; shared by the sequencer, its checker and its bench.
package fps_pkg;
	// ==========================================================
	// Widths and FIFO geometry
	localparam int BYTE_W     = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int CNT_W      = 5;
	localparam int THR_W      = 4;
	localparam int OPC_W      = 5;
	localparam int PAR_N      = 8;
	localparam int RIDX_W     = 3;
	localparam logic [CNT_W-1:0] FIFO_LAST = 5'h0F;
	localparam logic [CNT_W-1:0] CNT_ONE   = 5'h01;
	// ==========================================================
	// Disk option configuration byte
	localparam int CFG_MODE_HI   = 3;
	localparam int CFG_MODE_LO   = 2;
	localparam int CFG_BURST_BIT = 1;
	localparam logic [1:0] MODE_COMPACT = 2'h0;
	localparam logic [1:0] MODE_ALT     = 2'h1;
	localparam logic [1:0] MODE_RSVD    = 2'h2;
	localparam logic [1:0] MODE_AT      = 2'h3;
	// ==========================================================
	// Digital output register
	localparam int DOR_RST_BIT = 2;
	localparam int DOR_DMA_BIT = 3;
	localparam logic [BYTE_W-1:0] DOR_RESET_VAL = 8'h04;
	// ==========================================================
	// Command codes, parameter counts and parameter fields
	localparam logic [OPC_W-1:0] OP_SPECIFY   = 5'h03;
	localparam logic [OPC_W-1:0] OP_CONFIGURE = 5'h13;
	localparam logic [OPC_W-1:0] OP_READ      = 5'h06;
	localparam logic [OPC_W-1:0] OP_WRITE     = 5'h05;
	localparam logic [OPC_W-1:0] OP_VERIFY    = 5'h16;
	localparam logic [OPC_W-1:0] OP_SENSE     = 5'h08;
	localparam logic [3:0] NPAR_SPECIFY = 4'h2;
	localparam logic [3:0] NPAR_CONFIG  = 4'h3;
	localparam logic [3:0] NPAR_XFER    = 4'h8;
	localparam logic [3:0] NPAR_SENSE   = 4'h0;
	localparam int PIDX_SPEC_ND  = 1;
	localparam int SPEC_ND_BIT   = 0;
	localparam int PIDX_CFG      = 1;
	localparam int CFG_EFIFO_BIT = 5;
	localparam int PIDX_CYL      = 1;
	localparam int PIDX_HEAD     = 2;
	localparam int PIDX_SECTOR   = 3;
	localparam int PIDX_SIZE     = 4;
	localparam int PIDX_EOT      = 5;
	// ==========================================================
	// Result bytes
	localparam logic [RIDX_W-1:0] NRES_XFER  = 3'h7;
	localparam logic [RIDX_W-1:0] NRES_SENSE = 3'h2;
	localparam logic [BYTE_W-1:0] ST_CLEAR     = 8'h00;
	localparam logic [BYTE_W-1:0] ST0_ABNORMAL = 8'h40;
	localparam logic [BYTE_W-1:0] ST0_INVALID  = 8'h80;
	localparam logic [BYTE_W-1:0] ST1_EN       = 8'h80;
	localparam logic [BYTE_W-1:0] ST1_OR       = 8'h10;
	localparam logic [BYTE_W-1:0] SENSE_PCN    = 8'h00;
	localparam logic [BYTE_W-1:0] TX_FILL      = 8'h00;
	// ==========================================================
	// Controller phases, one-hot
	typedef enum logic [4:0] {
		ST_CMD   = 5'h01,
		ST_PROC  = 5'h02,
		ST_EXEC  = 5'h04,
		ST_RNEXT = 5'h08,
		ST_RES   = 5'h10
	} fps_phase_e;
endpackage : fps_pkg

// ---- verilog/fps_sequencer.sv ----
// Phase sequencer and DMA flow control of a floppy controller core, with its data FIFO.
// Assumes host, DMA and disk engine logic all run on clk_i; only nrst_i is asynchronous.
`timescale 1ns/1ps

// ==========================================================
// FIFO
module fps_fifo #(
	parameter int W  = 8,
	parameter int D  = 16,
	parameter int CW = $clog2(D) + 1
) (
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	input  wire logic          clr_i,
	input  wire logic          in_valid_i,
	output logic               in_ready_o,
	input  wire logic [W-1:0]  in_data_i,
	output logic               out_valid_o,
	input  wire logic          out_ready_i,
	output logic [W-1:0]       out_data_o,
	output logic [CW-1:0]      count_o
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [0:D-1];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [CW-1:0] cnt_r;
	logic          push;
	logic          pop;

	// Handshake and status
	assign in_ready_o  = cnt_r < CW'(D);
	assign out_valid_o = cnt_r != '0;
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	assign out_data_o  = mem[rp_r];
	assign count_o     = cnt_r;

	// Pointers and fill count; clear drops all contents
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else if (clr_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_r + AW'(push);
			rp_r  <= rp_r + AW'(pop);
			cnt_r <= cnt_r + CW'(push) - CW'(pop);
		end
	end

	// Storage
	always_ff @(posedge clk_i) begin
		if (push)
			mem[wp_r] <= in_data_i;
	end
endmodule : fps_fifo

// ==========================================================
// Sequencer top
module fps_sequencer (
	input  wire logic                         clk_i,
	input  wire logic                         nrst_i,
	input  wire logic [fps_pkg::BYTE_W-1:0]   disk_option_config_reg_i,
	input  wire logic                         dor_we_i,
	input  wire logic [fps_pkg::BYTE_W-1:0]   dor_wdata_i,
	output logic [fps_pkg::BYTE_W-1:0]        digital_output_reg_o,
	input  wire logic                         dsr_reset_i,
	input  wire logic                         high_density_i,
	output logic                              density_select_o,
	input  wire logic                         host_wr_i,
	input  wire logic [fps_pkg::BYTE_W-1:0]   host_wdata_i,
	input  wire logic                         host_rd_i,
	output logic [fps_pkg::BYTE_W-1:0]        host_rdata_o,
	output logic                              host_service_request_flag_o,
	output logic                              transfer_direction_flag_o,
	output logic                              command_busy_flag_o,
	output logic                              irq_o,
	output logic                              dma_req_o,
	input  wire logic                         dma_ack_i,
	input  wire logic [fps_pkg::BYTE_W-1:0]   dma_wdata_i,
	output logic [fps_pkg::BYTE_W-1:0]        dma_rdata_o,
	input  wire logic                         terminal_count_input_i,
	output logic                              exec_active_o,
	output logic                              exec_to_host_o,
	input  wire logic                         disk_rx_valid_i,
	input  wire logic [fps_pkg::BYTE_W-1:0]   disk_rx_data_i,
	input  wire logic                         disk_tx_req_i,
	output logic [fps_pkg::BYTE_W-1:0]        disk_tx_data_o,
	input  wire logic                         disk_sector_end_i
);
	import fps_pkg::*;

	logic               rst_s1_r, rst_n_r;
	logic [BYTE_W-1:0]  dor_r;
	fps_phase_e         state_r, st_nxt;
	logic               cb_r, cb_nxt;
	logic [OPC_W-1:0]   cmd_r, cmd_nxt;
	logic [3:0]         pcnt_r, pcnt_nxt;
	logic [BYTE_W-1:0]  par_r [0:PAR_N-1];
	logic               par_we;
	logic               dma_on_r, dma_on_nxt;
	logic               fifo_on_r, fifo_on_nxt;
	logic [THR_W-1:0]   thr_r, thr_nxt;
	logic [BYTE_W-1:0]  st0_r, st0_nxt, st1_r, st1_nxt, sec_r, sec_nxt;
	logic [RIDX_W-1:0]  ridx_r, ridx_nxt, nres_r, nres_nxt;
	logic               irq_r, irq_set, irq_clr, irq_nxt;
	logic               tc_r, done_r, en_r, err_r, req_r, req_nxt;
	logic [BYTE_W-1:0]  res_byte;
	logic [CNT_W-1:0]   fcnt;
	logic               f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_clr;
	logic [BYTE_W-1:0]  f_in_data, f_out_data;

	// ==========================================================
	// Reset release and soft reset
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_s1_r <= 1'h0;
			rst_n_r  <= 1'h0;
		end else begin
			rst_s1_r <= 1'h1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// Output register: pin reset leaves its reset bit set until host clears it
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r)
			dor_r <= DOR_RESET_VAL;
		else if (dor_we_i)
			dor_r <= dor_wdata_i;
	end

	// Core reset: held reset bit dominates the self-clearing pulse
	wire core_rst = dor_r[DOR_RST_BIT] | dsr_reset_i;

	// ==========================================================
	// Mode decode
	wire [1:0] mode    = disk_option_config_reg_i[CFG_MODE_HI:CFG_MODE_LO];
	wire       alt_md  = mode == MODE_ALT;
	wire       at_md   = (mode == MODE_AT) | (mode == MODE_RSVD);
	wire       gate_on = alt_md | dor_r[DOR_DMA_BIT];
	wire       burst   = disk_option_config_reg_i[CFG_BURST_BIT];
	wire       dens    = at_md ? high_density_i : ~high_density_i;

	// Command decode
	wire is_spec  = cmd_r == OP_SPECIFY;
	wire is_cfg   = cmd_r == OP_CONFIGURE;
	wire is_rd    = cmd_r == OP_READ;
	wire is_wr    = cmd_r == OP_WRITE;
	wire is_ver   = cmd_r == OP_VERIFY;
	wire is_sense = cmd_r == OP_SENSE;
	wire to_host  = is_rd | is_ver;
	wire op_valid = is_spec | is_cfg | is_rd | is_wr | is_ver | is_sense;
	wire [3:0] npar = is_spec ? NPAR_SPECIFY : is_cfg ? NPAR_CONFIG :
	                  is_sense ? NPAR_SENSE : NPAR_XFER;

	// ==========================================================
	// Execution bookkeeping
	wire in_exec  = state_r == ST_EXEC;
	wire tc_any   = tc_r | (in_exec & terminal_count_input_i);
	wire sec_end  = in_exec & disk_sector_end_i & ~done_r;
	wire last_sec = sec_r == par_r[PIDX_EOT];
	wire sec_fin  = sec_end & (tc_any | last_sec);
	wire sec_adv  = sec_end & ~tc_any & ~last_sec;
	wire en_ev    = sec_end & last_sec & ~tc_any;
	wire rd_src   = in_exec & to_host & disk_rx_valid_i & ~tc_any & ~done_r;
	wire [CNT_W-1:0] lim = fifo_on_r ? CNT_W'(FIFO_DEPTH) : CNT_ONE;
	wire room     = fcnt < lim;
	wire ovr_ev   = rd_src & ~room;
	wire udr_ev   = in_exec & ~to_host & disk_tx_req_i & ~f_out_valid & ~tc_any & ~done_r;
	wire exec_end = err_r | (done_r & ~f_out_valid);

	// FIFO steering: disk side and DMA side swap with direction
	assign f_in_valid  = to_host ? (rd_src & room) : (in_exec & dma_ack_i & ~tc_any & room);
	assign f_in_data   = to_host ? disk_rx_data_i : dma_wdata_i;
	assign f_out_ready = in_exec & (to_host ? dma_ack_i : disk_tx_req_i);
	assign f_clr       = core_rst | ~in_exec | err_r | (to_host & tc_any);

	// ==========================================================
	// DMA request levels
	wire [CNT_W-1:0] thr_cnt = {1'h0, thr_r} + CNT_ONE;
	wire [CNT_W-1:0] rd_full = FIFO_LAST - {1'h0, thr_r};
	wire [CNT_W-1:0] rd_lvl  = (fifo_on_r & (rd_full != '0)) ? rd_full : CNT_ONE;
	wire [CNT_W-1:0] wr_lvl  = fifo_on_r ? thr_cnt : '0;
	wire req_rd = f_out_valid & (req_r | (fcnt >= rd_lvl) | done_r);
	wire req_wr = room & (req_r | (fcnt <= wr_lvl)) & ~done_r;
	assign req_nxt = in_exec & ~tc_any & ~err_r & (to_host ? req_rd : req_wr);
	wire dreq_nxt = req_nxt & dma_on_r & gate_on & ~(dma_ack_i & ~burst);

	// Result byte selection
	always_comb begin
		unique case (ridx_r)
			3'h0:    res_byte = st0_r;
			3'h1:    res_byte = is_sense ? SENSE_PCN : st1_r;
			3'h2:    res_byte = ST_CLEAR;
			3'h3:    res_byte = par_r[PIDX_CYL];
			3'h4:    res_byte = par_r[PIDX_HEAD];
			3'h5:    res_byte = sec_r;
			default: res_byte = par_r[PIDX_SIZE];
		endcase
	end

	// ==========================================================
	// Phase sequencer
	always_comb begin
		st_nxt      = state_r;
		cb_nxt      = cb_r;
		cmd_nxt     = cmd_r;
		pcnt_nxt    = pcnt_r;
		dma_on_nxt  = dma_on_r;
		fifo_on_nxt = fifo_on_r;
		thr_nxt     = thr_r;
		st0_nxt     = st0_r;
		st1_nxt     = st1_r;
		sec_nxt     = sec_r;
		ridx_nxt    = ridx_r;
		nres_nxt    = nres_r;
		irq_set     = 1'h0;
		irq_clr     = 1'h0;
		par_we      = 1'h0;
		unique case (state_r)
			ST_CMD: if (host_wr_i) begin
				st_nxt = ST_PROC;
				cb_nxt = 1'h1;
				if (!cb_r)
					cmd_nxt = host_wdata_i[OPC_W-1:0];
				else begin
					par_we   = 1'h1;
					pcnt_nxt = pcnt_r + 4'h1;
				end
			end
			ST_PROC: if (!op_valid) begin
				st_nxt  = ST_CMD;
				cb_nxt  = 1'h0;
				irq_set = 1'h1;
				st0_nxt = ST0_INVALID;
			end else if (pcnt_r != npar) begin
				st_nxt = ST_CMD;
			end else begin
				pcnt_nxt = '0;
				if (is_spec) begin
					dma_on_nxt = ~par_r[PIDX_SPEC_ND][SPEC_ND_BIT];
					st_nxt     = ST_CMD;
					cb_nxt     = 1'h0;
				end else if (is_cfg) begin
					fifo_on_nxt = ~par_r[PIDX_CFG][CFG_EFIFO_BIT];
					thr_nxt     = par_r[PIDX_CFG][THR_W-1:0];
					st_nxt      = ST_CMD;
					cb_nxt      = 1'h0;
				end else if (is_sense) begin
					irq_clr  = 1'h1;
					nres_nxt = NRES_SENSE;
					ridx_nxt = '0;
					st_nxt   = ST_RNEXT;
				end else begin
					sec_nxt = par_r[PIDX_SECTOR];
					st_nxt  = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (sec_adv)
					sec_nxt = sec_r + 8'h01;
				if (exec_end) begin
					st_nxt   = ST_RNEXT;
					irq_set  = 1'h1;
					nres_nxt = NRES_XFER;
					ridx_nxt = '0;
					st0_nxt  = (err_r | en_r) ? ST0_ABNORMAL : ST_CLEAR;
					st1_nxt  = (en_r ? ST1_EN : ST_CLEAR) | (err_r ? ST1_OR : ST_CLEAR);
				end
			end
			ST_RNEXT: st_nxt = ST_RES;
			ST_RES: if (host_rd_i) begin
				if (ridx_r == '0)
					irq_clr = 1'h1;
				if (ridx_r == nres_r - 3'h1) begin
					st_nxt = ST_CMD;
					cb_nxt = 1'h0;
				end else begin
					ridx_nxt = ridx_r + 3'h1;
					st_nxt   = ST_RNEXT;
				end
			end
		endcase
	end

	// Interrupt: a new event wins over a clear in the same cycle
	assign irq_nxt = irq_set | (irq_r & ~irq_clr);

	// ==========================================================
	// Sequencer state
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r <= ST_CMD;
			cb_r    <= 1'h0;
			cmd_r   <= '0;
			pcnt_r  <= '0;
			irq_r   <= 1'h0;
		end else if (core_rst) begin
			state_r <= ST_CMD;
			cb_r    <= 1'h0;
			cmd_r   <= '0;
			pcnt_r  <= '0;
			irq_r   <= 1'h0;
		end else begin
			state_r <= st_nxt;
			cb_r    <= cb_nxt;
			cmd_r   <= cmd_nxt;
			pcnt_r  <= pcnt_nxt;
			irq_r   <= irq_nxt;
		end
	end

	// Drive-parameter setting survives soft resets
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r)
			dma_on_r <= 1'h0;
		else
			dma_on_r <= dma_on_nxt;
	end

	// Configure information and result data
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			fifo_on_r <= 1'h0;
			thr_r     <= '0;
			{st0_r, st1_r, sec_r} <= '0;
			{ridx_r, nres_r}      <= '0;
		end else if (core_rst) begin
			fifo_on_r <= 1'h0;
			thr_r     <= '0;
			{st0_r, st1_r, sec_r} <= '0;
			{ridx_r, nres_r}      <= '0;
		end else begin
			fifo_on_r <= fifo_on_nxt;
			thr_r     <= thr_nxt;
			{st0_r, st1_r, sec_r} <= {st0_nxt, st1_nxt, sec_nxt};
			{ridx_r, nres_r}      <= {ridx_nxt, nres_nxt};
		end
	end

	// Parameter bytes
	always_ff @(posedge clk_i) begin
		if (par_we)
			par_r[pcnt_r[2:0]] <= host_wdata_i;
	end

	// Transfer end tracking, cleared outside execution
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r)
			{tc_r, done_r, en_r, err_r, req_r} <= '0;
		else if (core_rst | ~in_exec)
			{tc_r, done_r, en_r, err_r, req_r} <= '0;
		else begin
			tc_r   <= tc_any;
			done_r <= done_r | sec_fin;
			en_r   <= en_r | en_ev;
			err_r  <= err_r | ovr_ev | udr_ev;
			req_r  <= req_nxt;
		end
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			host_service_request_flag_o <= 1'h0;
			transfer_direction_flag_o   <= 1'h0;
			command_busy_flag_o         <= 1'h0;
			irq_o            <= 1'h0;
			dma_req_o        <= 1'h0;
			density_select_o <= 1'h0;
			exec_active_o    <= 1'h0;
			exec_to_host_o   <= 1'h0;
		end else begin
			host_service_request_flag_o <= ~core_rst & ((st_nxt == ST_CMD) | (st_nxt == ST_RES));
			transfer_direction_flag_o   <= ~core_rst & (st_nxt == ST_RES);
			command_busy_flag_o         <= ~core_rst & cb_nxt;
			irq_o            <= ~core_rst & irq_nxt & gate_on;
			dma_req_o        <= ~core_rst & dreq_nxt;
			density_select_o <= dens;
			exec_active_o    <= ~core_rst & (st_nxt == ST_EXEC);
			exec_to_host_o   <= to_host;
		end
	end

	// Data outputs: results to host, FIFO bytes to DMA and disk
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			host_rdata_o   <= '0;
			dma_rdata_o    <= '0;
			disk_tx_data_o <= '0;
		end else begin
			host_rdata_o <= res_byte;
			if (f_out_ready & to_host)
				dma_rdata_o <= f_out_data;
			if (f_out_ready & ~to_host)
				disk_tx_data_o <= f_out_valid ? f_out_data : TX_FILL;
		end
	end

	assign digital_output_reg_o = dor_r;

	// ==========================================================
	// Data FIFO
	fps_fifo #(
		.W  (BYTE_W),
		.D  (FIFO_DEPTH),
		.CW (CNT_W)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_r),
		.clr_i       (f_clr),
		.in_valid_i  (f_in_valid),
		.in_ready_o  (f_in_ready),
		.in_data_i   (f_in_data),
		.out_valid_o (f_out_valid),
		.out_ready_i (f_out_ready),
		.out_data_o  (f_out_data),
		.count_o     (fcnt)
	);

	// Push is already limited by room; in the write direction a full FIFO also stalls the request via room
	wire unused_ready = f_in_ready;
endmodule : fps_sequencer
